// [design/opfb_pkg.sv]
package opfb_pkg;

  // ****************************************
  // Register sub-addresses and reset values.
  // ****************************************
  localparam logic [7:0]  ADDR_OUT_PIN   = 8'h10;
  localparam logic [7:0]  ADDR_FB_TWO    = 8'h31;
  localparam logic [7:0]  ADDR_FB_ONE    = 8'h32;
  localparam logic [7:0]  ADDR_IO_PORT   = 8'h34;
  localparam logic [7:0]  RST_BYTE_REG   = 8'h00;
  localparam logic [15:0] RST_IO_PORT    = 16'h0000;

  // ****************************************
  // Field codes.
  // ****************************************
  localparam logic [2:0] STRENGTH_TRISTATE = 3'h7;
  localparam logic [1:0] CSY_COMPOSITE     = 2'h0;
  localparam logic [1:0] CSY_FIELD_PARITY  = 2'h1;
  localparam logic [1:0] CSY_ZERO          = 2'h2;
  localparam logic [1:0] CSY_HDRIVE_CLK    = 2'h3;

  // ****************************************
  // Timing.
  // ****************************************
  localparam int CLK_HZ           = 40000000;
  localparam int HDRV_CLK_HZ      = 1000000;
  localparam int HDRV_HALF_CYCLES = CLK_HZ / (2 * HDRV_CLK_HZ);

  // ****************************************
  // Register layouts and bus request.
  // ****************************************
  typedef struct packed {
    logic [1:0] composite_pin_function;
    logic       deflection_resistor_enable;
    logic [1:0] reserved;
    logic [2:0] sync_drive_strength;
  } opfb_out_pin_type;

  typedef struct packed {
    logic       blank_one_force_low;
    logic [1:0] reserved;
    logic       flyback_polarity;
    logic       full_line_measure_window;
    logic       rgb_clamp_reference_enable;
    logic       blank_polarity;
    logic       blank_one_force_high;
  } opfb_fb_one_type;

  typedef struct packed {
    logic reserved;
    logic half_contrast_polarity;
    logic half_contrast_force_high;
    logic half_contrast_pin_enable;
    logic blank_monitor_select;
    logic blank_input_priority;
    logic blank_two_force_low;
    logic blank_two_force_high;
  } opfb_fb_two_type;

  typedef struct packed {
    logic       port_versus_color_select;
    logic [6:0] port_direction_bits;
    logic       front_sync_output_enable;
    logic [6:0] port_data_bits;
  } opfb_io_port_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } opfb_reg_req_type;

endpackage

// [design/opfb_output_pin_ctrl.sv]
// Notes on behaviour
// - Drive strength field sets both sync pins; value 7 tristates them.
// - Bit 5 of output pin register enables deflection output resistor.
// - Composite pin selects composite sync, field parity, zero or 1 MHz clock.
// - First blank follows its pin, or is forced high by bit 0.
// - First blank follows its pin, or is forced low by bit 7.
// - Blank polarity bit makes the blank inputs active low when set.
// - Bit 2 enables the RGB clamping reference.
// - Full line window bit overrides the measurement window control bit.
// - Flyback polarity bit makes the flyback input active low when set.
// - Second blank follows its pin, or is forced high by bit 0.
// - Second blank follows its pin, or is forced low by bit 1.
// - Priority bit chooses which blank input wins when both active.
// - Monitor select routes the first or second blank pin to monitor.
// - Half contrast enable takes port bit 0 away and enables half contrast.
// - Half contrast follows its pin, or is forced high.
// - Half contrast polarity bit makes the pin active low when set.
// - Port data drives output bits; reads return pin levels.
// - Front sync enable drives front sync out on port bit 1.
// - Direction bit n sets port bit n-8 as output when one.
// - Port select gives bits 6 to 2 either to colors or to port.
// - All four registers reset to zero.
module opfb_output_pin_ctrl #(
  parameter int PORT_WIDTH  = 7,
  parameter int COLOR_WIDTH = 5
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire opfb_pkg::opfb_reg_req_type   reg_req,
  output logic [15:0]                       reg_rdata,
  output logic                              reg_rvalid,
  input  wire logic                         main_sync_signal,
  input  wire logic                         composite_sync_signal,
  input  wire logic                         field_parity_signal,
  input  wire logic                         front_sync_signal,
  input  wire logic                         measure_window_ctrl,
  input  wire logic                         flyback_input,
  input  wire logic                         blank_input_one,
  input  wire logic                         blank_input_two,
  input  wire logic [COLOR_WIDTH-1:0]       color_signal,
  input  wire logic [PORT_WIDTH-1:0]        port_pin_in,
  output logic [2:0]                        sync_drive_strength,
  output logic                              main_sync_pin,
  output logic                              main_sync_oe,
  output logic                              composite_sync_pin,
  output logic                              composite_sync_oe,
  output logic                              deflection_resistor_enable,
  output logic                              blank_one_internal,
  output logic                              blank_two_internal,
  output logic                              blank_active,
  output logic                              blank_source_two,
  output logic                              blank_monitor,
  output logic                              rgb_clamp_reference_enable,
  output logic                              measure_window_full,
  output logic                              flyback_active,
  output logic                              half_contrast_active,
  output logic [PORT_WIDTH-1:0]             port_pin_out,
  output logic [PORT_WIDTH-1:0]             port_pin_oe,
  output logic [COLOR_WIDTH-1:0]            color_pin_out,
  output logic                              color_pin_oe
);

  // ****************************************
  // Functions.
  // ****************************************
  function automatic logic pin_level(input logic pin, input logic low_active,
                                     input logic force_high, input logic force_low);
    logic lvl;
    lvl = pin ^ low_active;
    if (force_high) begin
      lvl = 1'b1;
    end else if (force_low) begin
      lvl = 1'b0;
    end
    return lvl;
  endfunction

  // ****************************************
  // Registers.
  // ****************************************
  opfb_pkg::opfb_out_pin_type out_pin_r;
  opfb_pkg::opfb_fb_one_type  fb_one_r;
  opfb_pkg::opfb_fb_two_type  fb_two_r;
  opfb_pkg::opfb_io_port_type io_port_r;
  logic [15:0]                read_nxt;
  logic [4:0]                 hdrv_cnt_r;
  logic                       hdrv_clk_r;
  logic [PORT_WIDTH-1:0]      port_oe_nxt;
  logic [PORT_WIDTH-1:0]      port_out_nxt;
  logic                       one_nxt;
  logic                       two_nxt;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_pin_r <= opfb_pkg::RST_BYTE_REG;
      fb_one_r  <= opfb_pkg::RST_BYTE_REG;
      fb_two_r  <= opfb_pkg::RST_BYTE_REG;
      io_port_r <= opfb_pkg::RST_IO_PORT;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        opfb_pkg::ADDR_OUT_PIN: out_pin_r <= reg_req.wdata[7:0];
        opfb_pkg::ADDR_FB_ONE:  fb_one_r  <= reg_req.wdata[7:0];
        opfb_pkg::ADDR_FB_TWO:  fb_two_r  <= reg_req.wdata[7:0];
        opfb_pkg::ADDR_IO_PORT: io_port_r <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_req.addr)
      opfb_pkg::ADDR_OUT_PIN: read_nxt = {8'h00, out_pin_r};
      opfb_pkg::ADDR_FB_ONE:  read_nxt = {8'h00, fb_one_r};
      opfb_pkg::ADDR_FB_TWO:  read_nxt = {8'h00, fb_two_r};
      opfb_pkg::ADDR_IO_PORT: read_nxt = {io_port_r[15:7], port_pin_in};
      default:                read_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= read_nxt;
      end
    end
  end

  // ****************************************
  // Horizontal drive clock divider.
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hdrv_cnt_r <= 5'h00;
      hdrv_clk_r <= 1'b0;
    end else if (hdrv_cnt_r == 5'(opfb_pkg::HDRV_HALF_CYCLES - 1)) begin
      hdrv_cnt_r <= 5'h00;
      hdrv_clk_r <= ~hdrv_clk_r;
    end else begin
      hdrv_cnt_r <= hdrv_cnt_r + 5'h01;
    end
  end

  // ****************************************
  // Sync pins.
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_drive_strength        <= 3'h0;
      main_sync_oe               <= 1'b0;
      composite_sync_oe          <= 1'b0;
      main_sync_pin              <= 1'b0;
      composite_sync_pin         <= 1'b0;
      deflection_resistor_enable <= 1'b0;
    end else begin
      sync_drive_strength <= out_pin_r.sync_drive_strength;
      main_sync_oe        <= out_pin_r.sync_drive_strength != opfb_pkg::STRENGTH_TRISTATE;
      composite_sync_oe   <= out_pin_r.sync_drive_strength != opfb_pkg::STRENGTH_TRISTATE;
      main_sync_pin       <= main_sync_signal;
      deflection_resistor_enable <= out_pin_r.deflection_resistor_enable;
      case (out_pin_r.composite_pin_function)
        opfb_pkg::CSY_COMPOSITE:    composite_sync_pin <= composite_sync_signal;
        opfb_pkg::CSY_FIELD_PARITY: composite_sync_pin <= field_parity_signal;
        opfb_pkg::CSY_ZERO:         composite_sync_pin <= 1'b0;
        default:                    composite_sync_pin <= hdrv_clk_r;
      endcase
    end
  end

  // ****************************************
  // Fast blank and half contrast.
  // ****************************************
  assign one_nxt = pin_level(blank_input_one, fb_one_r.blank_polarity,
                             fb_one_r.blank_one_force_high, fb_one_r.blank_one_force_low);
  assign two_nxt = pin_level(blank_input_two, fb_one_r.blank_polarity,
                             fb_two_r.blank_two_force_high, fb_two_r.blank_two_force_low);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      blank_one_internal         <= 1'b0;
      blank_two_internal         <= 1'b0;
      blank_active               <= 1'b0;
      blank_source_two           <= 1'b0;
      blank_monitor              <= 1'b0;
      rgb_clamp_reference_enable <= 1'b0;
      measure_window_full        <= 1'b0;
      flyback_active             <= 1'b0;
      half_contrast_active       <= 1'b0;
    end else begin
      blank_one_internal <= one_nxt;
      blank_two_internal <= two_nxt;
      blank_active       <= one_nxt | two_nxt;
      blank_source_two   <= fb_two_r.blank_input_priority ? two_nxt : (two_nxt & ~one_nxt);
      blank_monitor      <= fb_two_r.blank_monitor_select ? blank_input_two : blank_input_one;
      rgb_clamp_reference_enable <= fb_one_r.rgb_clamp_reference_enable;
      measure_window_full <= fb_one_r.full_line_measure_window | measure_window_ctrl;
      flyback_active      <= flyback_input ^ fb_one_r.flyback_polarity;
      half_contrast_active <= pin_level(port_pin_in[0] & fb_two_r.half_contrast_pin_enable,
                                        fb_two_r.half_contrast_polarity &
                                        fb_two_r.half_contrast_pin_enable,
                                        fb_two_r.half_contrast_force_high, 1'b0);
    end
  end

  // ****************************************
  // General port and color pins.
  // ****************************************
  for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_port
    logic owned;
    if (i == 0) begin : g_bit0
      assign owned = ~fb_two_r.half_contrast_pin_enable;
    end else if (i == 1) begin : g_bit1
      assign owned = 1'b1;
    end else begin : g_high
      assign owned = io_port_r.port_versus_color_select;
    end
    if (i == 1) begin : g_fsy
      assign port_oe_nxt[i]  = owned & (io_port_r.front_sync_output_enable |
                                        io_port_r.port_direction_bits[i]);
      assign port_out_nxt[i] = io_port_r.front_sync_output_enable ? front_sync_signal
                                                                  : io_port_r.port_data_bits[i];
    end else begin : g_plain
      assign port_oe_nxt[i]  = owned & io_port_r.port_direction_bits[i];
      assign port_out_nxt[i] = io_port_r.port_data_bits[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_pin_oe   <= '0;
      port_pin_out  <= '0;
      color_pin_out <= '0;
      color_pin_oe  <= 1'b0;
    end else begin
      port_pin_oe   <= port_oe_nxt;
      port_pin_out  <= port_out_nxt;
      color_pin_out <= color_signal;
      color_pin_oe  <= ~io_port_r.port_versus_color_select;
    end
  end

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_sync_tristate: assert property (
    out_pin_r.sync_drive_strength == opfb_pkg::STRENGTH_TRISTATE |=>
    !main_sync_oe && !composite_sync_oe)
    else $error("Sync pins driven while strength is tristate.");
  a_resistor_write: assert property (
    reg_req.wr && reg_req.addr == opfb_pkg::ADDR_OUT_PIN |=> ##1
    deflection_resistor_enable == $past(reg_req.wdata[5], 2))
    else $error("Resistor enable does not follow register write.");
  a_csy_zero_out: assert property (
    out_pin_r.composite_pin_function == opfb_pkg::CSY_ZERO |=> !composite_sync_pin)
    else $error("Composite pin not zero in zero mode.");
  a_hdrv_period: assert property (
    $rose(hdrv_clk_r) |-> ##40 $rose(hdrv_clk_r))
    else $error("Horizontal drive clock period is not 40 cycles.");
  a_blank_force_high: assert property (
    fb_one_r.blank_one_force_high |=> blank_one_internal && blank_active)
    else $error("Forced high blank is not high.");
  a_blank_force_low: assert property (
    fb_one_r.blank_one_force_low && !fb_one_r.blank_one_force_high |=> !blank_one_internal)
    else $error("Forced low blank is not low.");
  a_blank_polarity: assert property (
    !fb_one_r.blank_one_force_high && !fb_one_r.blank_one_force_low |=>
    blank_one_internal == ($past(blank_input_one) ^ $past(fb_one_r.blank_polarity)))
    else $error("Blank one does not follow pin with polarity.");
  a_port_read: assert property (
    reg_req.rd && reg_req.addr == opfb_pkg::ADDR_IO_PORT |=>
    reg_rvalid && reg_rdata[6:0] == $past(port_pin_in))
    else $error("Port read does not return pin levels.");
  a_fsy_route: assert property (
    io_port_r.front_sync_output_enable |=>
    port_pin_oe[1] && port_pin_out[1] == $past(front_sync_signal))
    else $error("Front sync not driven on port bit 1.");
  a_color_select: assert property (
    !io_port_r.port_versus_color_select |=> port_pin_oe[6:2] == 5'h00 && color_pin_oe)
    else $error("Port bits 6 to 2 driven while colors own them.");
  a_half_port0: assert property (
    fb_two_r.half_contrast_pin_enable |=> !port_pin_oe[0])
    else $error("Port bit 0 driven while half contrast owns it.");
  a_reset_regs: assert property (
    $rose(rst_n) |-> out_pin_r == opfb_pkg::RST_BYTE_REG && fb_one_r == opfb_pkg::RST_BYTE_REG &&
    fb_two_r == opfb_pkg::RST_BYTE_REG && io_port_r == opfb_pkg::RST_IO_PORT)
    else $error("Registers not zero after reset.");
  a_blank_two_force: assert property (
    fb_two_r.blank_two_force_high |=> blank_two_internal && blank_active)
    else $error("Forced high second blank is not high.");
  a_blank_priority: assert property (
    fb_one_r.blank_one_force_high && fb_two_r.blank_two_force_high |=>
    blank_source_two == $past(fb_two_r.blank_input_priority))
    else $error("Blank source does not follow priority bit.");
  a_window_full: assert property (
    fb_one_r.full_line_measure_window |=> measure_window_full)
    else $error("Full line window bit does not override window control.");
  a_half_force: assert property (
    fb_two_r.half_contrast_force_high |=> half_contrast_active)
    else $error("Forced high half contrast is not high.");
  a_flyback_pol: assert property (
    rst_n |=> flyback_active == ($past(flyback_input) ^ $past(fb_one_r.flyback_polarity)))
    else $error("Flyback level does not follow pin with polarity.");

endmodule

// [test/opfb_host_model.sv]
module opfb_host_model (
  input  wire logic                 ref_clk,
  output opfb_pkg::opfb_reg_req_type reg_req,
  input  wire logic [15:0]          reg_rdata,
  input  wire logic                 reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Sub-address write and read accesses.
  // ****************************************
  initial reg_req = '0;

  function automatic logic [15:0] legal_bits(input logic [7:0] addr);
    case (addr)
      opfb_pkg::ADDR_OUT_PIN: legal_bits = 16'h00e7;
      opfb_pkg::ADDR_FB_TWO:  legal_bits = 16'h007f;
      opfb_pkg::ADDR_FB_ONE:  legal_bits = 16'h009f;
      default:                legal_bits = 16'hffff;
    endcase
  endfunction

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data & legal_bits(addr)};
    @(negedge ref_clk);
    reg_req = '0;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [15:0] data);
    int n;
    n = 0;
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(negedge ref_clk);
    reg_req = '0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    data = (n < 4) ? reg_rdata : 16'hxxxx;
  endtask
endmodule

// [test/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Clock, design and host.
  // ****************************************
  logic                       ref_clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       main_sync_signal = 1'b0, composite_sync_signal = 1'b0;
  logic                       field_parity_signal = 1'b0, front_sync_signal = 1'b0;
  logic                       measure_window_ctrl = 1'b0, flyback_input = 1'b0;
  logic                       blank_input_one = 1'b0, blank_input_two = 1'b0;
  logic [4:0]                 color_signal = 5'h00;
  logic [6:0]                 port_pin_in = 7'h00;
  opfb_pkg::opfb_reg_req_type reg_req;
  logic [15:0]                reg_rdata, rdv, io, g, e;
  logic [2:0]                 sync_drive_strength, p;
  logic [6:0]                 port_pin_out, port_pin_oe, oe, dat;
  logic [4:0]                 color_pin_out;
  logic                       reg_rvalid, main_sync_pin, main_sync_oe, composite_sync_pin;
  logic                       composite_sync_oe, deflection_resistor_enable, blank_one_internal;
  logic                       blank_two_internal, blank_active, blank_source_two, blank_monitor;
  logic                       rgb_clamp_reference_enable, measure_window_full, flyback_active;
  logic                       half_contrast_active, color_pin_oe, b1, b2;
  logic [7:0]                 v, w;
  int                         fails = 0;
  int                         tests_run = 0;
  int                         n;
  logic [7:0]                 addr_tab [5] = '{8'h10, 8'h31, 8'h32, 8'h34, 8'h33};
  logic [7:0]                 fb1_tab [8] = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h81, 8'h80, 8'h1c, 8'h00};
  logic [7:0]                 fb2_tab [8] = '{8'h00, 8'h04, 8'h08, 8'h02, 8'h03, 8'h10, 8'h50, 8'h20};
  logic [2:0]                 pin_tab [8] = '{3'h6, 3'h6, 3'h2, 3'h3, 3'h0, 3'h7, 3'h6, 3'h0};
  logic [15:0]                io_tab [4] = '{16'h7fd7, 16'hff55, 16'h8b2a, 16'h80ff};

  always #12.5 ref_clk = ~ref_clk;

  opfb_output_pin_ctrl dut_u (.*);
  opfb_host_model host_u (.ref_clk, .reg_req, .reg_rdata, .reg_rvalid);

  // ****************************************
  // Checking and closing tasks.
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic half_period(output int cnt);
    logic last;
    last = composite_sync_pin;
    cnt = 0;
    while (composite_sync_pin === last && cnt < 50) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    end_sim();
  end

  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    foreach (addr_tab[i]) begin
      host_u.rd(addr_tab[i], rdv);
      chk(rdv, 16'h0000, "reset read");
    end
    chk(16'({sync_drive_strength, main_sync_oe, composite_sync_oe}), 16'h0003, "rst pins");
    host_u.wr(opfb_pkg::ADDR_OUT_PIN, 16'h0007);
    settle();
    chk(16'({sync_drive_strength, main_sync_oe, composite_sync_oe}), 16'h001c, "tristate");
    host_u.wr(opfb_pkg::ADDR_OUT_PIN, 16'hff23);
    settle();
    g = 16'({sync_drive_strength, main_sync_oe, composite_sync_oe, deflection_resistor_enable});
    chk(g, 16'h001f, "strength");
    host_u.rd(opfb_pkg::ADDR_OUT_PIN, rdv);
    chk(rdv, 16'h0023, "out pin read");
    host_u.wr(8'h33, 16'hffff);
    host_u.rd(8'h33, rdv);
    chk(rdv, 16'h0000, "unmapped");
    for (int m = 0; m < 3; m++) begin
      host_u.wr(opfb_pkg::ADDR_OUT_PIN, 16'({m[1:0], 6'h00}));
      for (int s = 0; s < 2; s++) begin
        main_sync_signal = s[0];
        composite_sync_signal = s[0];
        field_parity_signal = ~s[0];
        settle();
        e = 16'({s[0], (m == 0) ? s[0] : (m == 1) ? ~s[0] : 1'b0});
        chk(16'({main_sync_pin, composite_sync_pin}), e, "sync pins");
      end
    end
    host_u.wr(opfb_pkg::ADDR_OUT_PIN, 16'h00c0);
    half_period(n);
    half_period(n);
    half_period(n);
    chk(16'(n), 16'(opfb_pkg::HDRV_HALF_CYCLES), "hdrive");
    for (int i = 0; i < 8; i++) begin
      v = fb1_tab[i];
      w = fb2_tab[i];
      p = pin_tab[i];
      host_u.wr(opfb_pkg::ADDR_FB_ONE, {8'h00, v});
      host_u.wr(opfb_pkg::ADDR_FB_TWO, {8'h00, w});
      {blank_input_one, blank_input_two, port_pin_in[0]} = p;
      measure_window_ctrl = i[0];
      flyback_input = i[1];
      settle();
      b1 = v[0] | (~v[7] & (p[2] ^ v[1]));
      b2 = w[0] | (~w[1] & (p[1] ^ v[1]));
      e = 16'({b1, b2, b1 | b2, w[2] ? b2 : b2 & ~b1, w[3] ? p[1] : p[2]});
      g = 16'({blank_one_internal, blank_two_internal, blank_active, blank_source_two,
               blank_monitor});
      chk(g, e, "blank");
      e = 16'({w[5] | (w[4] & (p[0] ^ w[6])), v[2], v[3] | i[0], i[1] ^ v[4]});
      g = 16'({half_contrast_active, rgb_clamp_reference_enable, measure_window_full,
               flyback_active});
      chk(g, e, "misc");
    end
    port_pin_in = 7'h33;
    color_signal = 5'h15;
    for (int k = 0; k < 4; k++) begin
      io = io_tab[k];
      host_u.wr(opfb_pkg::ADDR_FB_TWO, (k == 2) ? 16'h0010 : 16'h0000);
      host_u.wr(opfb_pkg::ADDR_IO_PORT, io);
      front_sync_signal = k[0];
      settle();
      oe = io[14:8] & (io[15] ? 7'h7f : 7'h03);
      oe[0] = oe[0] & (k != 2);
      oe[1] = oe[1] | io[7];
      dat = io[6:0];
      dat[1] = io[7] ? k[0] : io[1];
      chk(16'({port_pin_oe, port_pin_out & oe}), 16'({oe, dat & oe}), "port");
      g = 16'({color_pin_oe, color_pin_out & {5{~io[15]}}});
      chk(g, 16'({~io[15], color_signal & {5{~io[15]}}}), "color");
      host_u.rd(opfb_pkg::ADDR_IO_PORT, rdv);
      chk(rdv, {io[15:7], port_pin_in}, "port read");
    end
    end_sim();
  end
endmodule
